// [src/pll2_config_divider_bank.sv]
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "pll2_bank_map.svh"
// What this block does
// - Bit 7 at 26h picks spread direction
// - Divider A in 26h[6:0], resets 1
// - Divider B in 27h[6:0], resets 1
// - Two 32-bit sets, MSB-first over four bytes
// - Two-bit VCO band in set bits 1:0
// - Select bit per setting picks the set
// - Three control pins pick one setting
module pll2_config_divider_bank (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic [7:0] addr, // Register address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	output logic [7:0] rdata, // Read data, next cycle
	input wire logic control_pin_zero, // Setting select bit 0
	input wire logic control_pin_one, // Setting select bit 1
	input wire logic control_pin_two, // Setting select bit 2
	input wire logic src_clk_en_a, // Source tick for divider A
	input wire logic src_clk_en_b, // Source tick for divider B
	output logic clock_out_a, // Divided clock A
	output logic clock_out_b, // Divided clock B
	output pll2_bank_pkg::pll_cfg_s pll_cfg // Active loop setting
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic spread_direction_sel;
		logic [6:0] out_divider_a;
		logic div_b_msb;
		logic [6:0] out_divider_b;
		logic [31:0] freq_set_zero;
		logic [31:0] freq_set_one;
		logic [7:0] freq_set_select_bit;
		logic [7:0] rdata;
		pll2_bank_pkg::pll_cfg_s cfg;
	} bank_state_s;
	bank_state_s st_reg, st_next;
	pll2_bank_pkg::bus_req_s req;
	logic [2:0] setting_idx;
	logic active_sel;
	pll2_bank_pkg::freq_set_s active_set;

	// Byte index within a set, or 4 if not in that set
	function automatic logic [2:0] set_byte(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		set_byte = (a >= base && d < 8'h04) ? d[2:0] : 3'h4;
	endfunction : set_byte

	// Unpack a 32-bit image: 30-bit word then 2-bit band
	function automatic pll2_bank_pkg::freq_set_s unpack_set(input logic [31:0] w);
		unpack_set = pll2_bank_pkg::freq_set_s'(w);
	endfunction : unpack_set

	assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
	assign setting_idx = {control_pin_two, control_pin_one, control_pin_zero};
	assign active_sel = st_reg.freq_set_select_bit[setting_idx];
	assign active_set = active_sel ? unpack_set(st_reg.freq_set_one) : unpack_set(st_reg.freq_set_zero);

	// ****************************************
	// Register writes and reads
	// ****************************************
	always_comb begin
		logic [2:0] b0;
		logic [2:0] b1;
		b0 = set_byte(req.addr, `OFS_SET0_B0);
		b1 = set_byte(req.addr, `OFS_SET1_B0);
		st_next = st_reg;
		if (req.wr) begin
			if (req.addr == `OFS_DIR_DIV_A) begin
				st_next.spread_direction_sel = req.wdata[`DIR_BIT];
				st_next.out_divider_a = req.wdata[6:0];
			end
			if (req.addr == `OFS_DIV_B) begin
				st_next.div_b_msb = req.wdata[7];
				st_next.out_divider_b = req.wdata[6:0];
			end
			if (req.addr == `OFS_FS_SEL)
				st_next.freq_set_select_bit = req.wdata;
			if (b0 != 3'h4)
				st_next.freq_set_zero[(3 - b0) * `BYTE_W +: `BYTE_W] = req.wdata;
			if (b1 != 3'h4)
				st_next.freq_set_one[(3 - b1) * `BYTE_W +: `BYTE_W] = req.wdata;
		end
		st_next.rdata = `READ_ZERO;
		if (req.rd) begin
			if (req.addr == `OFS_DIR_DIV_A)
				st_next.rdata = {st_reg.spread_direction_sel, st_reg.out_divider_a};
			else if (req.addr == `OFS_DIV_B)
				st_next.rdata = {st_reg.div_b_msb, st_reg.out_divider_b};
			else if (req.addr == `OFS_FS_SEL)
				st_next.rdata = st_reg.freq_set_select_bit;
			else if (b0 != 3'h4)
				st_next.rdata = st_reg.freq_set_zero[(3 - b0) * `BYTE_W +: `BYTE_W];
			else if (b1 != 3'h4)
				st_next.rdata = st_reg.freq_set_one[(3 - b1) * `BYTE_W +: `BYTE_W];
		end
		// Registered loop word follows pins and bank
		st_next.cfg = '{spread_center: st_reg.spread_direction_sel, set: active_set, set_sel: active_sel};
	end

	// State register with documented defaults
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.out_divider_a <= `DIV_RST;
			st_reg.out_divider_b <= `DIV_RST;
			st_reg.freq_set_zero <= `SET_RST;
			st_reg.freq_set_one <= `SET_RST;
			st_reg.freq_set_select_bit <= `FS_RST;
			st_reg.cfg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
	assign pll_cfg = st_reg.cfg;

	// ****************************************
	// Output dividers
	// ****************************************
	out_divider #(.WIDTH(7)) u_div_a (
		.sys_clk(sys_clk),
		.rst(rst),
		.src_clk_en(src_clk_en_a),
		.ratio(st_reg.out_divider_a),
		.clk_out(clock_out_a)
	);
	out_divider #(.WIDTH(7)) u_div_b (
		.sys_clk(sys_clk),
		.rst(rst),
		.src_clk_en(src_clk_en_b),
		.ratio(st_reg.out_divider_b),
		.clk_out(clock_out_b)
	);
endmodule : pll2_config_divider_bank

// [common/pll2_bank_map.svh]
`ifndef PLL2_BANK_MAP_SVH
`define PLL2_BANK_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_DIR_DIV_A 8'h26
`define OFS_DIV_B 8'h27
`define OFS_SET0_B0 8'h28
`define OFS_SET0_B1 8'h29
`define OFS_SET0_B2 8'h2a
`define OFS_SET0_B3 8'h2b
`define OFS_SET1_B0 8'h2c
`define OFS_SET1_B1 8'h2d
`define OFS_SET1_B2 8'h2e
`define OFS_SET1_B3 8'h2f
`define OFS_FS_SEL 8'h23
// ****************************************
// Fields and reset values
// ****************************************
`define DIR_BIT 7
`define DIV_RST 7'h01
`define DIV_ZERO 7'h00
`define SET_RST 32'h0040_0208
`define FS_RST 8'h00
`define READ_ZERO 8'h00
`define BYTE_W 8
`endif

// [common/pll2_bank_pkg.sv]
package pll2_bank_pkg;
	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	// One frequency set: N R Q P band
	typedef struct packed {
		logic [11:0] n;
		logic [8:0] r;
		logic [5:0] q;
		logic [2:0] p;
		logic [1:0] band;
	} freq_set_s;
	// Word that drives the analog loop
	typedef struct packed {
		logic spread_center;
		freq_set_s set;
		logic set_sel;
	} pll_cfg_s;
endpackage : pll2_bank_pkg

// [src/out_divider.sv]
`timescale 1ns/1ps
`include "pll2_bank_map.svh"
// Integer clock divider; zero holds it in reset
module out_divider #(
	parameter int WIDTH = 7
) (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic src_clk_en, // Source clock tick
	input wire logic [WIDTH-1:0] ratio, // Division ratio
	output logic clk_out // Divided clock
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic out;
	} div_state_s;
	div_state_s st_reg, st_next;

	// Counter; output toggles at half period, static on zero or one
	always_comb begin
		st_next = st_reg;
		if (ratio == WIDTH'(0)) begin
			st_next.cnt = '0;
			st_next.out = 1'b0;
		end else if (src_clk_en) begin
			if (st_reg.cnt >= ratio - WIDTH'(1)) begin
				st_next.cnt = '0;
				st_next.out = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + WIDTH'(1);
				if (st_reg.cnt + WIDTH'(1) >= (ratio >> 1))
					st_next.out = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign clk_out = st_reg.out;
endmodule : out_divider

// [dv/pll2_bank_sva.sv]
`timescale 1ns/1ps
// ****
// Port checker
// ****
module pll2_bank_sva (
	input wire logic sys_clk, // In
	input wire logic rst, // In
	input wire logic [7:0] addr, // In
	input wire logic [7:0] wdata, // In
	input wire logic wr_stb, // In
	input wire logic rd_stb, // In
	input wire logic [7:0] rdata, // In
	input wire logic control_pin_zero, // In
	input wire logic control_pin_one, // In
	input wire logic control_pin_two, // In
	input wire logic src_clk_en_a, // In
	input wire logic src_clk_en_b, // In
	input wire logic clock_out_a, // In
	input wire logic clock_out_b, // In
	input wire pll2_bank_pkg::pll_cfg_s pll_cfg // In
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Write steps shared by the properties
	sequence wr26;
		wr_stb && addr == 8'h26;
	endsequence
	property wr_rd(a);
		wr_stb && addr == a ##1 rd_stb && addr == a |=> rdata == $past(wdata, 2);
	endproperty
	chk_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
		else $error("rdata not idle");
	chk_unmapped_read: assert property (rd_stb && addr != 8'h23 && !(addr inside {[8'h26:8'h2f]}) |=> rdata == 8'h00)
		else $error("unmapped read");
	chk_div_a_back: assert property (wr_rd(8'h26))
		else $error("readback 26");
	chk_div_b_back: assert property (wr_rd(8'h27))
		else $error("readback 27");
	chk_spread_dir: assert property (wr26 |=> ##1 pll_cfg.spread_center == $past(wdata[7], 2))
		else $error("spread dir");
	chk_reset_vals: assert property ($past(rst) && !rst |=> pll_cfg.set == 32'h0040_0208 && !pll_cfg.set_sel)
		else $error("reset set");
	chk_cfg_quiet: assert property ((!wr_stb && $stable({control_pin_two, control_pin_one, control_pin_zero})) [*3]
		|=> $stable(pll_cfg))
		else $error("cfg moved");
	chk_div_static: assert property (wr26 ##0 wdata[6:0] == 7'h00 |=> ##2 !clock_out_a [*4])
		else $error("divider not static");
endmodule : pll2_bank_sva
bind pll2_config_divider_bank pll2_bank_sva pll2_bank_sva_inst (.*);

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, rp = 1'b0, pb, sel;
	logic control_pin_zero = 1'b0, control_pin_one = 1'b0, control_pin_two = 1'b0;
	logic src_clk_en_a = 1'b0, src_clk_en_b = 1'b0, clock_out_a, clock_out_b;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx = 8'h00, rq;
	logic [7:0] m [256];
	logic [31:0] s;
	pll2_bank_pkg::pll_cfg_s pll_cfg;
	int err_total = 0, samples_checked = 0, seed = 32'h3617, k, j, n;
	pll2_config_divider_bank pll2_config_divider_bank_inst (.*);
	// ****
	// Clock, ticks, read data
	// ****
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (rp) check(rdata, rq);
		rp <= rd_stb;
		rq <= rx;
		src_clk_en_a <= ~src_clk_en_a;
	end
	task check(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask : check
	// One bus cycle; the model tracks mapped places
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= w;
		rd_stb <= !w;
		rx <= 8'h00;
		if (a == 8'h23 || a inside {[8'h26:8'h2f]}) begin
			rx <= m[a];
			if (w) m[a] = d;
		end
		@(posedge sys_clk);
	endtask : bus
	task idle();
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : idle
	task summarize();
		$display("mismatches %0d, compares %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// Main sequence
	initial begin
		m[8'h23] = 8'h00;
		m[8'h26] = 8'h01;
		m[8'h27] = 8'h01;
		{m[8'h28], m[8'h29], m[8'h2a], m[8'h2b]} = 32'h0040_0208;
		{m[8'h2c], m[8'h2d], m[8'h2e], m[8'h2f]} = 32'h0040_0208;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (j = 0; j < 7; j++) begin
			for (k = 8'h20; k < 8'h32; k++) bus(1'b0, k[7:0], 8'h00);
			idle();
			for (k = 0; k < 8; k++) begin
				{control_pin_two, control_pin_one, control_pin_zero} <= k[2:0];
				repeat (3) @(posedge sys_clk);
				sel = m[8'h23][k];
				s = sel ? {m[8'h2c], m[8'h2d], m[8'h2e], m[8'h2f]} : {m[8'h28], m[8'h29], m[8'h2a], m[8'h2b]};
				check(pll_cfg, {m[8'h26][7], s, sel});
			end
			s = {12'(1 + {$random(seed)} % 4095), 9'($random(seed)), 6'(16 + {$random(seed)} % 48), 3'($random(seed)), j[1:0]};
			for (k = 0; k < 4; k++) bus(1'b1, (j[0] ? 8'h2c : 8'h28) + k[7:0], s[31 - 8 * k -: 8]);
			bus(1'b1, 8'h26, 8'($random(seed)));
			bus(1'b1, 8'h27, 8'($random(seed)) & 8'h7f);
			bus(1'b1, 8'h23, 8'($random(seed)));
			bus(1'b1, 8'h31, 8'($random(seed)));
		end
		bus(1'b1, 8'h26, 8'h80);
		bus(1'b0, 8'h26, 8'h00);
		bus(1'b1, 8'h27, 8'h03);
		bus(1'b0, 8'h27, 8'h00);
		idle();
		src_clk_en_b <= 1'b1;
		repeat (9) @(posedge sys_clk);
		n = 0;
		pb = clock_out_b;
		repeat (30) begin
			@(posedge sys_clk);
			n += int'(clock_out_b && !pb);
			pb = clock_out_b;
		end
		check(n, 10);
		bus(1'b1, 8'h27, 8'h00);
		idle();
		repeat (4) @(posedge sys_clk);
		check(clock_out_b, 1'b0);
		check(clock_out_a, 1'b0);
		summarize();
	end
endmodule : testbench
